// >>> design/reset_ctrl_pkg.sv
package reset_ctrl_pkg;

    // ************************************************************
    // reset timing
    // ************************************************************
    localparam int CLK_NS         = 40;
    localparam int POR_TIME_NS    = 3000000;
    localparam int POR_CYCLES     = (POR_TIME_NS + CLK_NS - 1) / CLK_NS;
    localparam int SYNC_STAGES    = 3;
    localparam int REL_STAGES     = 2;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic RST_SRC_NONE = 1'b0;
    localparam logic [7:0] CAUSE_RST = 8'h00;

    // ************************************************************
    // cause bit positions
    // ************************************************************
    localparam int CAUSE_POR      = 0;
    localparam int CAUSE_PIN      = 1;
    localparam int CAUSE_SOFT     = 2;
    localparam int CAUSE_IO       = 3;
    localparam int CAUSE_CORE     = 4;

    typedef enum logic [1:0] {
        ST_OFF,
        ST_POR,
        ST_RESET,
        ST_STANDBY
    } seq_state_t;

endpackage

// >>> design/sensor_reset_control.sv
`timescale 1ns/1ps

// Functional notes
// - When supplies and the power-down pin rise from fully off, run a power-on reset, clear all registers and enter stand-by.
// - Supplies rising while the power-down pin is low do not start a power-on reset.
// - The power-down pin held low resets the whole device.
// - Writing the software reset bit resets the device.
// - The IO supply monitor resets the device while that supply is at or below 0.2V.
// - Loss of the core supply resets the device.
// - Any reset source returns all registers to their initial values; reset_cause is kept across every source and is cleared only by rstn.
// - In stand-by the register contents are kept until a software reset, the power-down pin or a supply loss clears them.
module sensor_reset_control #(
    parameter int POR_CNT = reset_ctrl_pkg::POR_CYCLES
) (
    // clock and async reset
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    // supply monitors and pins, asynchronous to clk_sys
    input  wire logic       core_supply_ok,
    input  wire logic       io_supply_ok,
    input  wire logic       power_down_pin,
    // software reset bit write strobe, same clock
    input  wire logic       soft_reset_bit,
    // outputs
    output logic            sys_rst_n,
    output logic            standby,
    output logic            por_busy,
    output logic [7:0]      reset_cause
);

    // ************************************************************
    // input synchronisers
    // ************************************************************
    logic [2:0] core_s_q;
    logic [2:0] io_s_q;
    logic [2:0] pin_s_q;
    logic       core_q;
    logic       io_q;
    logic       pin_q;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            core_s_q <= 3'h0;
            io_s_q   <= 3'h0;
            pin_s_q  <= 3'h0;
        end else begin
            core_s_q <= {core_s_q[1:0], core_supply_ok};
            io_s_q   <= {io_s_q[1:0], io_supply_ok};
            pin_s_q  <= {pin_s_q[1:0], power_down_pin};
        end
    end

    // a change counts only when stages two and three agree
    wire core_agree = (core_s_q[1] == core_s_q[2]);
    wire io_agree   = (io_s_q[1] == io_s_q[2]);
    wire pin_agree  = (pin_s_q[1] == pin_s_q[2]);

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            core_q <= 1'b0;
            io_q   <= 1'b0;
            pin_q  <= 1'b0;
        end else begin
            if (core_agree) begin
                core_q <= core_s_q[2];
            end
            if (io_agree) begin
                io_q <= io_s_q[2];
            end
            if (pin_agree) begin
                pin_q <= pin_s_q[2];
            end
        end
    end

    // ************************************************************
    // source decode
    // ************************************************************
    wire src_core  = !core_q;
    wire src_io    = !io_q;
    wire src_pin   = !pin_q;
    wire src_soft  = soft_reset_bit;
    wire supply_up = core_q && io_q;
    wire all_up    = supply_up && pin_q;
    wire any_hard  = src_core || src_io || src_pin;
    // supplies present behind a low pin: the detector never saw them rise
    wire por_missed = supply_up && !pin_q;

    // ************************************************************
    // sequencer
    // ************************************************************
    reset_ctrl_pkg::seq_state_t state_q;
    reset_ctrl_pkg::seq_state_t state_d;
    logic [31:0] cnt_q;
    logic        was_off_q;
    logic        live_q;

    wire por_done = (cnt_q >= 32'(POR_CNT - 1));

    // por only armed after both supplies were seen down
    wire off_seen = src_core && src_io;

    always_comb begin
        state_d = state_q;
        case (state_q)
            reset_ctrl_pkg::ST_OFF: begin
                // pin low keeps the detector itself powered down
                if (all_up && was_off_q) begin
                    state_d = reset_ctrl_pkg::ST_POR;
                end else if (all_up) begin
                    state_d = reset_ctrl_pkg::ST_RESET;
                end
            end
            reset_ctrl_pkg::ST_POR: begin
                if (any_hard) begin
                    state_d = reset_ctrl_pkg::ST_OFF;
                end else if (por_done) begin
                    state_d = reset_ctrl_pkg::ST_STANDBY;
                end
            end
            reset_ctrl_pkg::ST_RESET: begin
                if (any_hard) begin
                    state_d = reset_ctrl_pkg::ST_OFF;
                end else begin
                    state_d = reset_ctrl_pkg::ST_STANDBY;
                end
            end
            reset_ctrl_pkg::ST_STANDBY: begin
                if (any_hard) begin
                    state_d = reset_ctrl_pkg::ST_OFF;
                end else if (src_soft) begin
                    state_d = reset_ctrl_pkg::ST_RESET;
                end
            end
            default: state_d = reset_ctrl_pkg::ST_OFF;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_q <= reset_ctrl_pkg::ST_OFF;
            cnt_q   <= 32'h0;
        end else begin
            state_q <= state_d;
            cnt_q   <= (state_q == reset_ctrl_pkg::ST_POR) ? cnt_q + 32'h1 : 32'h0;
        end
    end

    // ************************************************************
    // power-on arming and cause qualifier
    // ************************************************************
    // limitation: a pin that settles after the supplies loses the
    // power-on count and takes the short reset path instead
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            was_off_q <= 1'b1;
            live_q    <= 1'b0;
        end else begin
            if (off_seen) begin
                was_off_q <= 1'b1;
            end else if (por_missed) begin
                was_off_q <= 1'b0;
            end else if (state_q == reset_ctrl_pkg::ST_POR) begin
                was_off_q <= 1'b0;
            end
            if (all_up) begin
                live_q <= 1'b1;
            end
        end
    end

    // ************************************************************
    // merged reset, synchronous release
    // ************************************************************
    // hard sources cut in on the edge they are seen, not one state later
    wire rst_req = (state_q != reset_ctrl_pkg::ST_STANDBY) || src_soft
                 || any_hard;
    logic [1:0] rel_q;

    // assert at once, release two edges later so every flop leaves together
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rel_q <= 2'h0;
        end else if (rst_req) begin
            rel_q <= 2'h0;
        end else begin
            rel_q <= {rel_q[0], 1'b1};
        end
    end

    // ************************************************************
    // cause capture
    // ************************************************************
    // hard causes wait for the first all-up: the synchronisers start low
    // after rstn and would otherwise flag every source at once
    logic [7:0] cause_set;

    always_comb begin
        cause_set                             = reset_ctrl_pkg::CAUSE_RST;
        cause_set[reset_ctrl_pkg::CAUSE_POR]  = (state_q == reset_ctrl_pkg::ST_POR);
        cause_set[reset_ctrl_pkg::CAUSE_PIN]  = live_q && src_pin;
        cause_set[reset_ctrl_pkg::CAUSE_SOFT] = src_soft;
        cause_set[reset_ctrl_pkg::CAUSE_IO]   = live_q && src_io;
        cause_set[reset_ctrl_pkg::CAUSE_CORE] = live_q && src_core;
    end

    // ************************************************************
    // outputs
    // ************************************************************

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            sys_rst_n   <= 1'b0;
            standby     <= 1'b0;
            por_busy    <= 1'b0;
            reset_cause <= reset_ctrl_pkg::CAUSE_RST;
        end else begin
            sys_rst_n   <= rel_q[1] && !rst_req;
            standby     <= (state_q == reset_ctrl_pkg::ST_STANDBY) && rel_q[1] && !rst_req;
            por_busy    <= (state_q == reset_ctrl_pkg::ST_POR);
            // sticky, cleared only by the async reset
            reset_cause <= reset_cause | cause_set;
        end
    end

endmodule

// >>> sim/reset_ctrl_asserts.sv
`timescale 1ns/1ps
module reset_ctrl_asserts (
    // clock and reset
    input wire logic       clk_sys,
    input wire logic       rstn,
    // sources
    input wire logic       core_supply_ok,
    input wire logic       io_supply_ok,
    input wire logic       power_down_pin,
    input wire logic       soft_reset_bit,
    // results
    input wire logic       sys_rst_n,
    input wire logic       standby,
    input wire logic       por_busy,
    input wire logic [7:0] reset_cause
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    property p_soft; soft_reset_bit |-> ##[1:2] !sys_rst_n; endproperty
    property p_pin; $fell(power_down_pin) |-> ##[1:8] !sys_rst_n; endproperty
    property p_io; $fell(io_supply_ok) |-> ##[1:8] !sys_rst_n; endproperty
    property p_core; $fell(core_supply_ok) |-> ##[1:8] !sys_rst_n; endproperty
    property p_stby; standby |-> sys_rst_n && !por_busy; endproperty
    property p_por; por_busy |-> !sys_rst_n; endproperty
    // a held pin keeps the part down and the power-on count idle
    property p_hold; !power_down_pin [*8] |-> !sys_rst_n && !por_busy && !standby; endproperty
    property p_cause; soft_reset_bit |-> ##[1:3] reset_cause[2]; endproperty
    a_soft: assert property (p_soft) else $error("soft strobe gave no reset");
    a_pin: assert property (p_pin) else $error("pin low gave no reset");
    a_io: assert property (p_io) else $error("io supply loss gave no reset");
    a_core: assert property (p_core) else $error("core loss gave no reset");
    a_stby: assert property (p_stby) else $error("standby while in reset");
    a_por: assert property (p_por) else $error("released during count");
    a_hold: assert property (p_hold) else $error("pin low not held");
    a_cause: assert property (p_cause) else $error("soft cause not set");
    c_stby: cover property ($rose(standby));
    c_soft: cover property (soft_reset_bit);
    c_io: cover property ($fell(io_supply_ok));
endmodule
bind sensor_reset_control reset_ctrl_asserts u_chk (.clk_sys(clk_sys), .rstn(rstn),
    .core_supply_ok(core_supply_ok), .io_supply_ok(io_supply_ok),
    .power_down_pin(power_down_pin), .soft_reset_bit(soft_reset_bit),
    .sys_rst_n(sys_rst_n), .standby(standby), .por_busy(por_busy),
    .reset_cause(reset_cause));

// >>> sim/host_supply_model.sv
`timescale 1ns/1ps
module host_supply_model (
    input  wire logic clk_sys,
    output logic      core_supply_ok,
    output logic      io_supply_ok,
    output logic      power_down_pin
);
    initial begin
        {core_supply_ok, io_supply_ok, power_down_pin} = 3'h7;
    end
    // order {core, io, pin}; all three start high and set_src changes them together on a falling edge
    task automatic set_src(input logic [2:0] v);
        @(negedge clk_sys);
        {core_supply_ok, io_supply_ok, power_down_pin} = v;
    endtask
endmodule

// >>> sim/test_sensor_reset_control.sv
`timescale 1ns/1ps
module test_sensor_reset_control;
    logic       clk_sys = 1'b0;
    logic       rstn = 1'b0;
    logic       soft_reset_bit = 1'b0;
    logic       core_supply_ok, io_supply_ok, power_down_pin;
    logic       sys_rst_n, standby, por_busy;
    logic [7:0] reset_cause;
    int         mismatches = 0;
    int         check_count = 0;
    always #20 clk_sys = ~clk_sys;
    host_supply_model u_host (.clk_sys(clk_sys), .core_supply_ok(core_supply_ok),
        .io_supply_ok(io_supply_ok), .power_down_pin(power_down_pin));
    sensor_reset_control #(.POR_CNT(8)) u_dut (.clk_sys(clk_sys), .rstn(rstn),
        .core_supply_ok(core_supply_ok), .io_supply_ok(io_supply_ok),
        .power_down_pin(power_down_pin), .soft_reset_bit(soft_reset_bit),
        .sys_rst_n(sys_rst_n), .standby(standby), .por_busy(por_busy),
        .reset_cause(reset_cause));
    // ****************
    // helpers
    // ****************
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wait_rel;
        for (int i = 0; i < 100 && sys_rst_n !== 1'b1; i++)
            @(negedge clk_sys);
        chk("sys_rst_n", 8'h01, {7'h00, sys_rst_n});
    endtask
    task automatic t_por;
        logic seen = 1'b0;
        for (int i = 0; i < 20; i++) begin
            @(negedge clk_sys);
            seen |= (por_busy === 1'b1);
        end
        chk("por_busy", 8'h01, {7'h00, seen});
        wait_rel();
        chk("standby", 8'h01, {7'h00, standby});
        chk("cause_por", 8'h01, {7'h00, reset_cause[reset_ctrl_pkg::CAUSE_POR]});
        chk("reset_cause", 8'h01, reset_cause);
        $display("done por");
    endtask
    task automatic t_soft;
        logic held = 1'b1;
        for (int i = 0; i < 10; i++) begin
            @(negedge clk_sys);
            held &= (sys_rst_n === 1'b1) && (standby === 1'b1);
        end
        chk("held", 8'h01, {7'h00, held});
        soft_reset_bit = 1'b1;
        @(negedge clk_sys);
        soft_reset_bit = 1'b0;
        @(negedge clk_sys);
        chk("sys_rst_n", 8'h00, {7'h00, sys_rst_n});
        wait_rel();
        chk("cause_soft", 8'h01, {7'h00, reset_cause[reset_ctrl_pkg::CAUSE_SOFT]});
        $display("done soft");
    endtask
    task automatic t_hard(input int idx, input int cb);
        logic [2:0] v = 3'h7;
        v[idx] = 1'b0;
        u_host.set_src(v);
        repeat (8) @(negedge clk_sys);
        chk("sys_rst_n", 8'h00, {7'h00, sys_rst_n});
        chk("standby", 8'h00, {7'h00, standby});
        u_host.set_src(3'h7);
        wait_rel();
        chk("cause", 8'h01, {7'h00, reset_cause[cb]});
        $display("done source %0d", idx);
    endtask
    task automatic t_pin_first;
        logic seen = 1'b0;
        @(negedge clk_sys);
        rstn = 1'b0;
        u_host.set_src(3'h6);
        rstn = 1'b1;
        for (int i = 0; i < 20; i++) begin
            @(negedge clk_sys);
            seen |= (por_busy !== 1'b0);
        end
        chk("por_busy", 8'h00, {7'h00, seen});
        u_host.set_src(3'h7);
        for (int i = 0; i < 20; i++) begin
            @(negedge clk_sys);
            seen |= (por_busy !== 1'b0);
        end
        chk("por_busy", 8'h00, {7'h00, seen});
        wait_rel();
        chk("standby", 8'h01, {7'h00, standby});
        chk("cause_por", 8'h00, {7'h00, reset_cause[reset_ctrl_pkg::CAUSE_POR]});
        $display("done pin first");
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (10) @(negedge clk_sys);
        rstn = 1'b1;
        t_por();
        t_soft();
        t_hard(0, reset_ctrl_pkg::CAUSE_PIN);
        t_hard(1, reset_ctrl_pkg::CAUSE_IO);
        t_hard(2, reset_ctrl_pkg::CAUSE_CORE);
        t_pin_first();
        complete_run();
    end
    initial begin
        repeat (3000) @(posedge clk_sys);
        mismatches++;
        complete_run();
    end
endmodule
